// *** include/watchdog_pkg.sv ***
package watchdog_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] MODE_OFF  = 8'h00;
  localparam logic [7:0] CTRL_OFF  = 8'h04;
  localparam logic [7:0] STAT_OFF  = 8'h08;
  localparam logic [7:0] COUNT_OFF = 8'h0C;

  //////////////////////////////////////////////////////////////////////////
  // mode register fields
  localparam int          MODE_VAL_LSB     = 0;
  localparam int          MODE_VAL_W       = 12;
  localparam int          MODE_FIEN_BIT    = 12;
  localparam int          MODE_RSTEN_BIT   = 13;
  localparam int          MODE_DIS_BIT     = 15;
  localparam int          MODE_DBGHLT_BIT  = 28;
  localparam int          MODE_IDLEHLT_BIT = 29;
  localparam logic [31:0] MODE_USED_MASK   = 32'h3000_BFFF;
  localparam logic [31:0] MODE_RESET       = 32'h0000_8FFF;

  //////////////////////////////////////////////////////////////////////////
  // control and status fields
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_KEY_LSB     = 24;
  localparam int CTRL_KEY_W       = 8;
  localparam int STAT_UNF_BIT     = 0;
  localparam int STAT_ERR_BIT     = 1;

  //////////////////////////////////////////////////////////////////////////
  // slow clock prescaler and bus answers
  localparam int         PRESCALE_DIV = 128;
  localparam int         PRESCALE_W   = 7;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage

// *** core/watchdog_countdown.sv ***
`timescale 1ns/1ps
module watchdog_countdown
  import watchdog_pkg::*;
#(
  parameter int CNT_W = MODE_VAL_W
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             slow_tick,
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [CNT_W-1:0] load_value,
  // state
  output logic      [CNT_W-1:0] count,
  output logic                  underflow
);

  logic [PRESCALE_W-1:0] presc_reg;
  logic [CNT_W-1:0]      count_reg;
  logic                  unf_reg;
  logic                  step;

  // one decrement per full prescaler period of slow ticks
  assign step = run && slow_tick
             && (presc_reg == PRESCALE_W'(PRESCALE_DIV - 1));

  // prescaler: cleared and restarted on every restart
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      presc_reg <= '0;
    end else if (run && slow_tick) begin
      presc_reg <= presc_reg + PRESCALE_W'(1);
    end
  end

  // down counter, reloads on restart and after an underflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      unf_reg   <= 1'b0;
    end else begin
      unf_reg <= 1'b0;
      if (restart) begin
        count_reg <= load_value;
      end else if (step) begin
        if (count_reg == '0) begin
          unf_reg   <= 1'b1;
          count_reg <= load_value;
        end else begin
          count_reg <= count_reg - CNT_W'(1);
        end
      end
    end
  end

  assign count     = count_reg;
  assign underflow = unf_reg;

endmodule // watchdog_countdown

// *** core/safety_watchdog.sv ***
`timescale 1ns/1ps
// Functional notes
// - the mode register takes only its first write after a processor reset.
// - the first mode write reloads the counter and restarts the countdown.
// - a restart command reloads the counter and restarts the prescaler.
// - control writes without the correct key field only set the error flag.
// - underflow with reset enable set asserts the fault line.
// - every underflow sets the underflow flag.
// - the interrupt follows underflow or error flag when enabled.
// - a fault leads to a reset that clears the watchdog and its flags.
// - reset or a status read clears flags, interrupt and fault line.
// - after power-on the watchdog is disabled.
// - debug or idle state freezes the counter when its halt bit is set.
module safety_watchdog
  import watchdog_pkg::*;
#(
  parameter int         CNT_W    = MODE_VAL_W,
  parameter logic [7:0] CTRL_KEY = 8'hA5 // arbitrary key value
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // processor state and slow clock
  input  wire logic        slow_tick,
  input  wire logic        debug_state,
  input  wire logic        idle_state,
  // toward interrupt and reset controllers
  output logic             watchdog_irq,
  output logic             watchdog_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge written bytes into an old word under the byte strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // word address decode, true for a mapped register
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == MODE_OFF) || (addr == CTRL_OFF)
        || (addr == STAT_OFF) || (addr == COUNT_OFF);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]       aw_addr_reg;
  logic             aw_held_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             w_held_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [1:0]       rresp_reg;
  logic [31:0]      rdata_reg;
  logic [31:0]      mode_reg;
  logic             mode_locked_reg;
  logic             unf_flag_reg;
  logic             err_flag_reg;
  logic             fault_reg;
  logic             irq_reg;
  logic             wr_fire;
  logic             rd_fire;
  logic             mode_wr;
  logic             ctrl_wr;
  logic             key_ok;
  logic             restart_cmd;
  logic             reload;
  logic             stat_read;
  logic             halted;
  logic             run;
  logic             underflow;
  logic [CNT_W-1:0] count;
  logic [31:0]      ctrl_word;
  logic             unf_next;
  logic             err_next;
  logic [31:0]      mode_next;
  logic [31:0]      load_word;

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  // a new half is refused until the response is taken, so one write at
  // most is under way
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

  // hold the write address until the data is also present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // hold the write data until the address is also present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  // a status read clears the flags at its address edge, while the data
  // word still carries the flags as they stood before the clear
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign stat_read     = rd_fire && (s_axi_araddr[7:2] == STAT_OFF[7:2]);

  // read data is captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        MODE_OFF:  rdata_reg <= mode_reg;
        STAT_OFF: begin
          rdata_reg[STAT_UNF_BIT] <= unf_flag_reg;
          rdata_reg[STAT_ERR_BIT] <= err_flag_reg;
        end
        COUNT_OFF: rdata_reg[CNT_W-1:0] <= count;
        CTRL_OFF:  rdata_reg <= 32'h0000_0000; // write only
        default:   rresp_reg <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp  = rresp_reg;
  assign s_axi_rdata  = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register write decode

  assign mode_wr     = wr_fire && (aw_addr_reg == MODE_OFF);
  assign ctrl_wr     = wr_fire && (aw_addr_reg == CTRL_OFF);
  assign ctrl_word   = merge_bytes(32'h0000_0000, w_data_reg, w_strb_reg);
  assign key_ok      = ctrl_word[CTRL_KEY_LSB +: CTRL_KEY_W] == CTRL_KEY;
  assign restart_cmd = ctrl_wr && key_ok
                    && ctrl_word[CTRL_RESTART_BIT];
  assign reload      = restart_cmd
                    || (mode_wr && !mode_locked_reg);

  // word that the first mode write leaves behind; the countdown loads from
  // it at the write edge, since the mode register still shows the old word
  // during that cycle
  assign mode_next = merge_bytes(mode_reg, w_data_reg, w_strb_reg)
                   & MODE_USED_MASK;
  assign load_word = (mode_wr && !mode_locked_reg) ? mode_next
                                                   : mode_reg;

  // mode register: first write only, reset value keeps it disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg        <= MODE_RESET;
      mode_locked_reg <= 1'b0;
    end else if (mode_wr && !mode_locked_reg) begin
      mode_reg        <= mode_next;
      mode_locked_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // countdown

  // the power-on mode word has the disable bit set, so nothing counts
  // freeze in debug or idle state when the matching halt bit is set
  assign halted = (debug_state && mode_reg[MODE_DBGHLT_BIT])
               || (idle_state && mode_reg[MODE_IDLEHLT_BIT]);
  assign run    = !mode_reg[MODE_DIS_BIT] && !halted;

  watchdog_countdown #(
    .CNT_W (CNT_W)
  ) u_countdown (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .slow_tick  (slow_tick),
    .run        (run),
    .restart    (reload),
    .load_value (load_word[MODE_VAL_LSB +: CNT_W]),
    .count      (count),
    .underflow  (underflow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags, interrupt and fault line

  // a new event wins over a clearing status read in the same cycle
  // an error is a control write whose key field does not match
  assign unf_next = underflow || (unf_flag_reg && !stat_read);
  assign err_next = (ctrl_wr && !key_ok)
                 || (err_flag_reg && !stat_read);

  // sticky flags
  // any reset, the watchdog reset included, returns both to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unf_flag_reg <= 1'b0;
      err_flag_reg <= 1'b0;
    end else begin
      unf_flag_reg <= unf_next;
      err_flag_reg <= err_next;
    end
  end

  // interrupt level tracks the flags when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= mode_reg[MODE_FIEN_BIT] && (unf_next || err_next);
    end
  end

  // fault toward the reset controller, held until read or reset
  // with reset enable clear an underflow only sets the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_reg <= 1'b0;
    end else if (underflow && mode_reg[MODE_RSTEN_BIT]) begin
      fault_reg <= 1'b1;
    end else if (stat_read) begin
      fault_reg <= 1'b0;
    end
  end

  assign watchdog_irq   = irq_reg;
  assign watchdog_fault = fault_reg;

endmodule // safety_watchdog

// *** bench/safety_watchdog_props.sv ***
`timescale 1ns/1ps
module safety_watchdog_props
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // write channels
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  // read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  // toward controllers
  input wire logic       watchdog_irq,
  input wire logic       watchdog_fault
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic stat_hs;
  logic bad_addr;
  // status read handshake and unmapped address decode
  assign stat_hs  = s_axi_arvalid && s_axi_arready
                    && (s_axi_araddr[7:2] == STAT_OFF[7:2]);
  assign bad_addr = s_axi_araddr[7:2] > COUNT_OFF[7:2];
  sequence rd_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_rd_answer: assert property (rd_hs |=> s_axi_rvalid)
    else $error("read not answered");
  chk_wr_answer: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_rd_slverr: assert property (rd_hs ##0 bad_addr |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_rd_okay: assert property (rd_hs ##0 !bad_addr |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_fault_clear: assert property ($fell(watchdog_fault) |-> $past(stat_hs))
    else $error("fault dropped without status read");
  chk_irq_clear: assert property ($fell(watchdog_irq) |-> $past(stat_hs))
    else $error("interrupt dropped without status read");
endmodule // safety_watchdog_props

bind safety_watchdog safety_watchdog_props chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .watchdog_irq(watchdog_irq),
  .watchdog_fault(watchdog_fault));

// *** bench/reset_ctrl_model.sv ***
`timescale 1ns/1ps
module reset_ctrl_model (
  // clock and power-on reset
  input  wire logic aclk,
  input  wire logic por_n,
  // fault line and whether it is honoured
  input  wire logic arm,
  input  wire logic fault,
  // reset toward the watchdog
  output logic      aresetn
);
  logic [2:0] hold_reg;
  // a fault starts a four cycle reset pulse
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      hold_reg <= 3'h0;
    end else if (arm && fault && hold_reg == 3'h0) begin
      hold_reg <= 3'h4;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  // power-on or watchdog reset
  assign aresetn = por_n && (hold_reg == 3'h0);
endmodule // reset_ctrl_model

// *** bench/safety_watchdog_bench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: got %h expected %h", $time, (g), (e)); end end
module safety_watchdog_bench
  import watchdog_pkg::*;
();
  localparam logic [7:0] KEY = 8'hA5; // arbitrary key value
  logic        aclk, por_n, aresetn, arm, tick, dbg, idle, irq, fault;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          err_total = 0;
  int          n_compared = 0;
  int          n;
  ////////////////////////////////////////
  safety_watchdog #(.CTRL_KEY(KEY)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .slow_tick(tick), .debug_state(dbg), .idle_state(idle),
    .watchdog_irq(irq), .watchdog_fault(fault));
  reset_ctrl_model rst_u (.aclk(aclk), .por_n(por_n), .arm(arm),
    .fault(fault), .aresetn(aresetn));
  ////////////////////////////////////////
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  // bus read, data compared only on an okay answer
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(rresp, er)
    if (er == RESP_OKAY) `CHK(rdata, ed)
  endtask
  // cycles until the fault line rises
  task automatic wait_fault(output int c);
    c = 0;
    while (fault !== 1'b1) begin
      @(posedge aclk);
      c++;
    end
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // clock and slow tick every other cycle
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) tick <= (tick !== 1'b1); // single driver
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish;
  end
  // test sequence
  initial begin
    {por_n, arm, dbg, idle, awvalid, wvalid, bready} = 7'h00;
    {arvalid, rready, awaddr, araddr, wdata} = 50'h0;
    repeat (5) @(posedge aclk);
    por_n <= 1'b1;
    rd(MODE_OFF, MODE_RESET, RESP_OKAY);
    repeat (600) @(posedge aclk);
    rd(COUNT_OFF, 32'h0, RESP_OKAY);
    rd(STAT_OFF, 32'h0, RESP_OKAY);
    $display("test power_on done");
    wr(MODE_OFF, 32'h0000_3003, RESP_OKAY);
    rd(COUNT_OFF, 32'h3, RESP_OKAY);
    wr(MODE_OFF, MODE_RESET, RESP_OKAY);
    rd(MODE_OFF, 32'h0000_3003, RESP_OKAY);
    $display("test write_once done");
    repeat (300) @(posedge aclk);
    rd(COUNT_OFF, 32'h2, RESP_OKAY);
    wr(CTRL_OFF, {~KEY, 24'h1}, RESP_OKAY);
    rd(COUNT_OFF, 32'h2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    rd(STAT_OFF, 32'h2, RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(CTRL_OFF, {KEY, 24'h1}, RESP_OKAY);
    rd(COUNT_OFF, 32'h3, RESP_OKAY);
    $display("test key done");
    wait_fault(n);
    `CHK(n >= 1016 && n <= 1028, 1'b1)
    `CHK(irq, 1'b1)
    rd(STAT_OFF, 32'h1, RESP_OKAY);
    `CHK(fault, 1'b0)
    `CHK(irq, 1'b0)
    $display("test underflow done");
    arm <= 1'b1;
    wait_fault(n);
    while (aresetn !== 1'b0) @(posedge aclk);
    while (aresetn !== 1'b1) @(posedge aclk);
    rd(MODE_OFF, MODE_RESET, RESP_OKAY);
    rd(STAT_OFF, 32'h0, RESP_OKAY);
    $display("test fault_reset done");
    dbg <= 1'b1;
    wr(MODE_OFF, 32'h1000_0001, RESP_OKAY);
    repeat (600) @(posedge aclk);
    rd(COUNT_OFF, 32'h1, RESP_OKAY);
    dbg <= 1'b0;
    idle <= 1'b1;
    repeat (300) @(posedge aclk);
    rd(COUNT_OFF, 32'h0, RESP_OKAY);
    repeat (300) @(posedge aclk);
    `CHK(fault, 1'b0)
    `CHK(irq, 1'b0)
    rd(STAT_OFF, 32'h1, RESP_OKAY);
    $display("test halt done");
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    rd(MODE_OFF, MODE_RESET, RESP_OKAY);
    wr(MODE_OFF, 32'h2000_0001, RESP_OKAY);
    repeat (600) @(posedge aclk);
    rd(COUNT_OFF, 32'h1, RESP_OKAY);
    $display("test idle_halt done");
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(CTRL_OFF, 32'h0, RESP_OKAY);
    $display("test bus done");
    tally_and_finish;
  end
endmodule // safety_watchdog_bench
